// ===== logic/boot_source_mode_control.sv
// Boot-source selection: forced ROM field, boot source flags, NMI gate, vectors.
// Assumes porResetn comes only from power-on; rstn covers every system reset.
// Assumes sysResetRelease pulses one cycle after each system reset is released.
`timescale 1ns/1ps
//
// Contract
// - Forced field cleared only by power-on reset
// - Nonzero forced field makes later resets boot ROM
// - Forced value sets matching boot source flags
// - Reserved bits read zero, writes ignored
// - Boot inputs captured at each chip reset
// - Flags stay until system reset or W1C
// - Flag set blocks NMI, vectors from ROM
// - Source code: flash, pin, option, both
module boot_source_mode_control #(
  parameter int ADDR_WIDTH = boot_mode_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic porResetn,
  input wire logic sysResetRelease,
  input wire logic bootConfigPin,
  input wire logic [7:0] flashOptionByte,
  input wire logic nmiIn,
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [boot_mode_pkg::DATA_W-1:0] avs_writedata,
  output logic [boot_mode_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic nmiOut,
  output logic [31:0] vectorBase,
  output logic romBoot
);
  import boot_mode_pkg::*;

  // Decoder compares against fixed 32-bit addresses
  if (ADDR_WIDTH != ADDR_W) begin : gBadAddrWidth
    $error("ADDR_WIDTH must be 32");
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle gives a registered read and a single write strobe
  logic ack;
  logic [1:0] forcedRomBootSelect;
  logic [1:0] bootSourceFlags;
  logic [1:0] capturedSource;
  logic hitForce;
  logic hitStatus;
  logic doWrite;

  assign hitForce = (avs_address == FORCE_BOOT_CONTROL_BYTE);
  assign hitStatus = (avs_address == BOOT_SOURCE_STATUS_BYTE);
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign doWrite = avs_write && ack && avs_byteenable[0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack) begin
      if (hitForce) begin
        avs_readdata <= {29'h0000_0000, forcedRomBootSelect, 1'b0};
      end else if (hitStatus) begin
        avs_readdata <= {29'h0000_0000, bootSourceFlags, 1'b0};
      end else begin
        avs_readdata <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Forced ROM field
  // ----------------------------------------------------------------
  // Kept on its own reset so warm resets cannot undo a forced boot
  always_ff @(posedge clk or negedge porResetn) begin
    if (!porResetn) begin
      forcedRomBootSelect <= FIELD_RESET;
    end else if (doWrite && hitForce) begin
      forcedRomBootSelect <= avs_writedata[FIELD_MSB:FIELD_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Boot source capture and flags
  // ----------------------------------------------------------------
  boot_source_latch capture (
    .clk(clk),
    .rstn(rstn),
    .chipResetDone(sysResetRelease),
    .bootConfigPin(bootConfigPin),
    .flashOptionByte(flashOptionByte),
    .forcedRomBootSelect(forcedRomBootSelect),
    .capturedSource(capturedSource)
  );

  // Pin cause arrives through the synchroniser, merged one cycle later
  logic captureLate;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      captureLate <= 1'b0;
    end else begin
      captureLate <= sysResetRelease;
    end
  end

  logic [1:0] next_flags;
  always_comb begin
    next_flags = bootSourceFlags;
    if (doWrite && hitStatus) begin
      next_flags = next_flags & ~avs_writedata[FIELD_MSB:FIELD_LSB];
    end
    if (sysResetRelease) begin
      next_flags = {flashOptionByte[OPTION_BOOT_BIT], 1'b0} | forcedRomBootSelect;
    end
    // Merged after the clear, so a capture beats a same-cycle W1C
    if (captureLate) begin
      next_flags = next_flags | capturedSource;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bootSourceFlags <= SRC_FLASH;
    end else begin
      bootSourceFlags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // ROM boot effects
  // ----------------------------------------------------------------
  function automatic logic romSelected(input logic [1:0] flags);
    return flags != SRC_FLASH;
  endfunction

  // Driven from next_flags so the effects line up with the flag register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmiOut <= 1'b0;
      vectorBase <= FLASH_VECTOR_BASE;
      romBoot <= 1'b0;
    end else begin
      nmiOut <= nmiIn && !romSelected(next_flags);
      vectorBase <= romSelected(next_flags) ? ROM_VECTOR_BASE : FLASH_VECTOR_BASE;
      romBoot <= romSelected(next_flags);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence reqSeq;
    (avs_read || avs_write) && !ack;
  endsequence

  sequence captureSeq;
    sysResetRelease ##1 captureLate;
  endsequence

  bus_answer_a: assert property (@(posedge clk) disable iff (!rstn)
    reqSeq |=> !avs_waitrequest || !(avs_read || avs_write))
    else $error("Bus answer late");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    (avs_readdata[0] == 1'b0) && (avs_readdata[31:3] == '0))
    else $error("Reserved bits nonzero");
  unmapped_read_a: assert property (@(posedge clk) disable iff (!rstn)
    avs_read && !ack && !hitForce && !hitStatus |=> avs_readdata == '0)
    else $error("Unmapped read nonzero");
  status_read_a: assert property (@(posedge clk) disable iff (!rstn)
    avs_read && !ack && hitStatus |=>
    avs_readdata[FIELD_MSB:FIELD_LSB] == $past(bootSourceFlags))
    else $error("Status read wrong");
  force_read_a: assert property (@(posedge clk) disable iff (!rstn || !porResetn)
    avs_read && !ack && hitForce |=>
    avs_readdata[FIELD_MSB:FIELD_LSB] == $past(forcedRomBootSelect))
    else $error("Force read wrong");

  force_write_a: assert property (@(posedge clk) disable iff (!rstn || !porResetn)
    doWrite && hitForce |=>
    forcedRomBootSelect == $past(avs_writedata[FIELD_MSB:FIELD_LSB]))
    else $error("Force field not written");
  force_hold_a: assert property (@(posedge clk) disable iff (!rstn || !porResetn)
    !(doWrite && hitForce) |=> $stable(forcedRomBootSelect))
    else $error("Force field changed");

  clear_one_a: assert property (@(posedge clk) disable iff (!rstn)
    doWrite && hitStatus && avs_writedata[1] && !sysResetRelease && !captureLate
    |=> !bootSourceFlags[0])
    else $error("Flag not cleared");
  zero_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    !sysResetRelease && !captureLate && !(doWrite && hitStatus) |=> $stable(bootSourceFlags))
    else $error("Flag changed without cause");
  forced_set_a: assert property (@(posedge clk) disable iff (!rstn || !porResetn)
    captureSeq |=>
    (bootSourceFlags & $past(forcedRomBootSelect, 2)) == $past(forcedRomBootSelect, 2))
    else $error("Forced flags missing");
  option_capture_a: assert property (@(posedge clk) disable iff (!rstn || !porResetn)
    sysResetRelease |=> bootSourceFlags[1] ==
    ($past(flashOptionByte[OPTION_BOOT_BIT]) || $past(forcedRomBootSelect[1])))
    else $error("Option cause not captured");
  pin_merge_a: assert property (@(posedge clk) disable iff (!rstn)
    captureSeq |=> bootSourceFlags[0] || !$past(capturedSource[0]))
    else $error("Pin cause not merged");

  // Effects are checked against the flag register, except nmi_pass_a, which uses the next value
  rom_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    romBoot == (bootSourceFlags != SRC_FLASH))
    else $error("ROM boot flag wrong");
  nmi_block_a: assert property (@(posedge clk) disable iff (!rstn)
    bootSourceFlags != SRC_FLASH |-> !nmiOut)
    else $error("NMI passed in ROM boot");
  nmi_pass_a: assert property (@(posedge clk) disable iff (!rstn)
    next_flags == SRC_FLASH |=> nmiOut == $past(nmiIn))
    else $error("NMI not passed in flash boot");
  vector_rom_a: assert property (@(posedge clk) disable iff (!rstn)
    vectorBase == ((bootSourceFlags != SRC_FLASH) ? ROM_VECTOR_BASE : FLASH_VECTOR_BASE))
    else $error("Vector base wrong");
endmodule

// ===== logic/boot_mode_pkg.sv
// Shared constants for the boot-source selection block.
// Assumes a byte-wide register view placed on a 32-bit Avalon-MM slave.
package boot_mode_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] FORCE_BOOT_CONTROL_ADDR = 32'h4007_f006;
  localparam logic [31:0] BOOT_SOURCE_STATUS_ADDR = 32'h4007_f007;
  localparam int REG_INDEX_BASE = 32'h4007_f000;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  // Offsets are not word aligned, so byte address is index times four
  localparam logic [ADDR_W-1:0] FORCE_BOOT_CONTROL_BYTE = 32'h0000_0018;
  localparam logic [ADDR_W-1:0] BOOT_SOURCE_STATUS_BYTE = 32'h0000_001c;
  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int FIELD_LSB = 1;
  localparam int FIELD_MSB = 2;
  localparam logic [1:0] FIELD_RESET = 2'h0;
  localparam logic [1:0] SRC_FLASH = 2'h0;
  localparam logic [1:0] SRC_PIN = 2'h1;
  localparam logic [1:0] SRC_OPTION = 2'h2;
  localparam int OPTION_BOOT_BIT = 7;
  localparam logic [31:0] ROM_VECTOR_BASE = 32'h1c00_0000;
  localparam logic [31:0] FLASH_VECTOR_BASE = 32'h0000_0000;
endpackage

// ===== logic/boot_source_latch.sv
// Capture of the boot source at each chip reset.
// Assumes pins are stable while chip reset is asserted.
`timescale 1ns/1ps
module boot_source_latch (
  input wire logic clk,
  input wire logic rstn,
  input wire logic chipResetDone,
  input wire logic bootConfigPin,
  input wire logic [7:0] flashOptionByte,
  input wire logic [1:0] forcedRomBootSelect,
  output logic [1:0] capturedSource
);
  import boot_mode_pkg::*;
  logic pinMeta;
  logic pinSync;

  // Pin passes two flops before use; left free running through reset so
  // the pin level is already through them when the release pulse arrives
  always_ff @(posedge clk) begin
    pinMeta <= bootConfigPin;
    pinSync <= pinMeta;
  end

  // Pin and option causes merged with any forced request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capturedSource <= SRC_FLASH;
    end else if (chipResetDone) begin
      capturedSource <= {flashOptionByte[OPTION_BOOT_BIT], pinSync} | forcedRomBootSelect;
    end
  end
endmodule

// ===== test/boot_source_mode_control_test.sv
// Testbench for the boot-source selection block: register access and reset capture.
// Assumes the design package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module boot_source_mode_control_test;
  import boot_mode_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and design
  // ----------------------------------------------------------------
  logic clk = 0, rstn = 0, porResetn = 0, sysResetRelease = 0;
  logic bootConfigPin = 0, nmiIn = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [7:0] flashOptionByte = 8'h00;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_address = 32'h0000_0000, avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, vectorBase, rd;
  logic nmiOut, romBoot;
  int num_errors = 0, total_checks = 0;
  boot_source_mode_control uut (.clk(clk), .rstn(rstn), .porResetn(porResetn),
    .sysResetRelease(sysResetRelease), .bootConfigPin(bootConfigPin),
    .flashOptionByte(flashOptionByte), .nmiIn(nmiIn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .nmiOut(nmiOut), .vectorBase(vectorBase),
    .romBoot(romBoot));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge, then one
  // idle edge so back-to-back calls never reassign a strobe in one step
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // System reset, or power-on reset as well, then the release pulse
  task automatic sysreset(input logic por);
    rstn <= 1'b0;
    porResetn <= !por;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    porResetn <= 1'b1;
    @(posedge clk);
    sysResetRelease <= 1'b1;
    @(posedge clk);
    sysResetRelease <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    porResetn <= 1'b1;
    @(posedge clk);
    bus(1'b0, FORCE_BOOT_CONTROL_BYTE, 32'h0);
    check(rd, 32'h0000_0000);
    bus(1'b0, 32'h0000_0020, 32'h0);
    check(rd, 32'h0000_0000);
    // Writes with byte lane 0 off, or to no register, are dropped
    avs_byteenable <= 4'he;
    bus(1'b1, FORCE_BOOT_CONTROL_BYTE, 32'h0000_0006);
    avs_byteenable <= 4'h1;
    bus(1'b1, 32'h0000_0020, 32'h0000_0006);
    bus(1'b0, FORCE_BOOT_CONTROL_BYTE, 32'h0);
    check(rd, 32'h0000_0000);
    // Forced values, with reserved bits 0 and 3 to 7 written as ones
    for (int f = 1; f < 4; f++) begin
      bus(1'b1, FORCE_BOOT_CONTROL_BYTE, 32'h0000_00f9 | 32'(f << 1));
      sysreset(1'b0);
      bus(1'b0, FORCE_BOOT_CONTROL_BYTE, 32'h0);
      check(rd, 32'(f << 1));
      bus(1'b0, BOOT_SOURCE_STATUS_BYTE, 32'h0);
      check(rd, 32'(f << 1));
      check(vectorBase, ROM_VECTOR_BASE);
      check(32'(nmiOut), 32'h0000_0000);
    end
    // Partial clear leaves the other flag; zero bits are ignored
    bus(1'b1, BOOT_SOURCE_STATUS_BYTE, 32'h0000_00fb);
    bus(1'b0, BOOT_SOURCE_STATUS_BYTE, 32'h0);
    check(rd, 32'h0000_0004);
    bus(1'b1, BOOT_SOURCE_STATUS_BYTE, 32'h0000_0004);
    bus(1'b0, BOOT_SOURCE_STATUS_BYTE, 32'h0);
    check(rd, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check(32'(nmiOut), 32'h0000_0001);
    check(vectorBase, FLASH_VECTOR_BASE);
    nmiIn <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'(nmiOut), 32'h0000_0000);
    nmiIn <= 1'b1;
    bus(1'b1, FORCE_BOOT_CONTROL_BYTE, 32'h0);
    // Every pin and option combination with no forcing
    for (int p = 0; p < 4; p++) begin
      bootConfigPin <= p[0];
      flashOptionByte <= p[1] ? 8'h80 : 8'h7f;
      sysreset(1'b0);
      bus(1'b0, BOOT_SOURCE_STATUS_BYTE, 32'h0);
      check(rd, 32'(p << 1));
      check(32'(romBoot), 32'(p != 0));
    end
    bootConfigPin <= 1'b0;
    flashOptionByte <= 8'h00;
    sysreset(1'b0);
    bus(1'b0, BOOT_SOURCE_STATUS_BYTE, 32'h0);
    check(rd, 32'h0000_0000);
    bus(1'b1, FORCE_BOOT_CONTROL_BYTE, 32'h0000_0004);
    sysreset(1'b1);
    bus(1'b0, FORCE_BOOT_CONTROL_BYTE, 32'h0);
    check(rd, 32'h0000_0000);
    final_report();
  end
endmodule
